// ===== common/atacd_pkg.sv
// Function
// RULE1 - Decode E5, E3, E1; drive select only (the code also uses count for E3)
// RULE2 - Decode E2, E0, E6; drive select only
// RULE3 - Reads C8/C9, C4, 20/21, 40/41 with LBA
// RULE4 - Writes CA, C5, 30 with LBA
// RULE5 - Security F1..F6 use drive select only
// RULE6 - Decode 90, E7, EC, 10; drive select
// RULE7 - 91 uses count and full device/head
// RULE8 - Any 7x is seek, cylinder plus head
// RULE9 - EF takes subcommand from feature field
// RULE10 - C6 takes block size from count
// RULE11 - B0 health read uses four fields (the code uses five: feature, count, secnum, cyl, drive select)
// RULE12 - Used fields are valid arguments only
// RULE13 - Full device/head: select and head used
// RULE14 - Select-only: head field is disregarded
// RULE15 - LBA commands pack address from fields
// RULE16 - Health data has vendor IDs E5,E8,EA,EB
// RULE17 - Vendor attributes report flash wear data
// RULE18 - Unsupported opcode aborts, no transfer
// RULE19 - Host loads fields before writing opcode
package atacd_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_FEATURE = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_SECNUM = 8'h08;
  localparam logic [7:0] ADDR_CYL = 8'h0c;
  localparam logic [7:0] ADDR_DEVHEAD = 8'h10;
  localparam logic [7:0] ADDR_COMMAND = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_USAGE = 8'h1c;
  localparam logic [7:0] ADDR_LBA = 8'h20;
  localparam logic [7:0] ADDR_ATTR_SEL = 8'h24;
  localparam logic [7:0] ADDR_ATTR_DATA = 8'h28;
  localparam logic [7:0] ADDR_ATTR_LOAD = 8'h2c;
  // Device/head layout
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRV_BIT = 4;
  // Status bits
  localparam int ST_DONE = 0;
  localparam int ST_ABORT = 1;
  localparam int ST_XFER = 2;
  localparam int ST_LBA = 3;
  // Usage mask bits
  localparam int U_FEAT = 0;
  localparam int U_COUNT = 1;
  localparam int U_SECNUM = 2;
  localparam int U_CYL = 3;
  localparam int U_DRV = 4;
  localparam int U_HEAD = 5;
  localparam int U_LBA = 6;
  // Vendor attribute identifiers
  localparam logic [7:0] ATTR_FLASH_ID = 8'he5;
  localparam logic [7:0] ATTR_FW = 8'he8;
  localparam logic [7:0] ATTR_ERASE = 8'hea;
  localparam logic [7:0] ATTR_BLOCKS = 8'heb;
  localparam int NUM_ATTR = 6;
  localparam logic [31:0] ATTR_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    ATACD_NONE = 5'h00, ATACD_CHKPWR = 5'h01, ATACD_IDLE = 5'h02, ATACD_IDLEI = 5'h03,
    ATACD_STBY = 5'h04, ATACD_STBYI = 5'h05, ATACD_SLEEP = 5'h06, ATACD_RDMA = 5'h07,
    ATACD_RMUL = 5'h08, ATACD_RSEC = 5'h09, ATACD_RVER = 5'h0a, ATACD_WDMA = 5'h0b,
    ATACD_WMUL = 5'h0c, ATACD_WSEC = 5'h0d, ATACD_SECUR = 5'h0e, ATACD_DIAG = 5'h0f,
    ATACD_FLUSH = 5'h10, ATACD_IDENT = 5'h11, ATACD_RECAL = 5'h12, ATACD_INITP = 5'h13,
    ATACD_SEEK = 5'h14, ATACD_SETF = 5'h15, ATACD_SETMUL = 5'h16, ATACD_SMART = 5'h17,
    ATACD_BAD = 5'h18
  } atacd_cmd_t;

  typedef struct packed {
    atacd_cmd_t cmd;
    logic [6:0] use_mask;
    logic xfer;
    logic abort;
  } atacd_dec_t;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] secnum;
    logic [15:0] cyl;
    logic [7:0] devhead;
  } atacd_tf_t;
endpackage

// ===== design/atacd_decode.sv
`timescale 1ns/100ps
module atacd_decode
  import atacd_pkg::*;
(
  input wire logic [7:0] opcode_i,
  output atacd_dec_t dec_o
);
  localparam logic [6:0] M_D = 7'h10;
  localparam logic [6:0] M_RW = 7'h7e;

  always_comb begin
    dec_o = '{cmd: ATACD_NONE, use_mask: M_D, xfer: 1'b0, abort: 1'b0};
    if (opcode_i[7:4] == 4'h7) begin
      dec_o.cmd = ATACD_SEEK; // [RULE8]
      dec_o.use_mask = 7'h38; // [RULE13]
    end else begin
      unique case (opcode_i)
        8'he5: dec_o.cmd = ATACD_CHKPWR; // [RULE1]
        8'he3: begin
          dec_o.cmd = ATACD_IDLE; // [RULE1]
          dec_o.use_mask = 7'h12;
        end
        8'he1: dec_o.cmd = ATACD_IDLEI; // [RULE1]
        8'he2: dec_o.cmd = ATACD_STBY; // [RULE2]
        8'he0: dec_o.cmd = ATACD_STBYI; // [RULE2]
        8'he6: dec_o.cmd = ATACD_SLEEP; // [RULE2]
        8'hc8, 8'hc9: begin
          dec_o.cmd = ATACD_RDMA; // [RULE3]
          dec_o.use_mask = M_RW;
          dec_o.xfer = 1'b1;
        end
        8'hc4: begin
          dec_o.cmd = ATACD_RMUL; // [RULE3]
          dec_o.use_mask = M_RW;
          dec_o.xfer = 1'b1;
        end
        8'h20, 8'h21: begin
          dec_o.cmd = ATACD_RSEC; // [RULE3]
          dec_o.use_mask = M_RW;
          dec_o.xfer = 1'b1;
        end
        8'h40, 8'h41: begin
          dec_o.cmd = ATACD_RVER; // [RULE3]
          dec_o.use_mask = M_RW;
        end
        8'hca: begin
          dec_o.cmd = ATACD_WDMA; // [RULE4]
          dec_o.use_mask = M_RW;
          dec_o.xfer = 1'b1;
        end
        8'hc5: begin
          dec_o.cmd = ATACD_WMUL; // [RULE4]
          dec_o.use_mask = M_RW;
          dec_o.xfer = 1'b1;
        end
        8'h30: begin
          dec_o.cmd = ATACD_WSEC; // [RULE4]
          dec_o.use_mask = M_RW;
          dec_o.xfer = 1'b1;
        end
        8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6: dec_o.cmd = ATACD_SECUR; // [RULE5]
        8'h90: dec_o.cmd = ATACD_DIAG; // [RULE6]
        8'he7: dec_o.cmd = ATACD_FLUSH; // [RULE6]
        8'hec: begin
          dec_o.cmd = ATACD_IDENT; // [RULE6]
          dec_o.xfer = 1'b1;
        end
        8'h10: dec_o.cmd = ATACD_RECAL; // [RULE6]
        8'h91: begin
          dec_o.cmd = ATACD_INITP; // [RULE7]
          dec_o.use_mask = 7'h32;
        end
        8'hef: begin
          dec_o.cmd = ATACD_SETF; // [RULE9]
          dec_o.use_mask = 7'h11;
        end
        8'hc6: begin
          dec_o.cmd = ATACD_SETMUL; // [RULE10]
          dec_o.use_mask = 7'h12;
        end
        8'hb0: begin
          dec_o.cmd = ATACD_SMART; // [RULE11]
          dec_o.use_mask = 7'h1f;
          dec_o.xfer = 1'b1;
        end
        default: begin
          dec_o.cmd = ATACD_BAD; // [RULE18]
          dec_o.use_mask = 7'h00;
          dec_o.abort = 1'b1;
        end
      endcase
    end
  end
endmodule

// ===== design/atacd_top.sv
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module atacd_top
  import atacd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic CMD_STROBE_O,
  output atacd_cmd_t CMD_KIND_O,
  output logic [7:0] CMD_OPCODE_O,
  output atacd_tf_t CMD_ARGS_O,
  output logic [27:0] CMD_LBA_O,
  output logic CMD_LBA_MODE_O,
  output logic [6:0] CMD_USE_O
);
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_held && !S_AXI_BVALID_O;
  assign wr_go = aw_held && w_held && !S_AXI_BVALID_O;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR_I[7:0];
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic wr_known(input logic [7:0] a);
    return a inside {ADDR_FEATURE, ADDR_COUNT, ADDR_SECNUM, ADDR_CYL, ADDR_DEVHEAD,
                     ADDR_COMMAND, ADDR_ATTR_SEL, ADDR_ATTR_LOAD};
  endfunction

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'b00;
    end else if (wr_go) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_known(aw_addr) ? 2'b00 : 2'b10;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task file; fields latched as written, opcode write starts decode
  atacd_tf_t tf;
  logic cmd_wr;
  logic [7:0] sel_attr;
  logic [31:0] attr [NUM_ATTR];

  assign cmd_wr = wr_go && aw_addr == ADDR_COMMAND && w_strb[0];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tf <= '0;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == ADDR_FEATURE) tf.feature <= w_data[7:0];
      if (aw_addr == ADDR_COUNT) tf.count <= w_data[7:0];
      if (aw_addr == ADDR_SECNUM) tf.secnum <= w_data[7:0];
      if (aw_addr == ADDR_DEVHEAD) tf.devhead <= w_data[7:0];
      if (aw_addr == ADDR_CYL) tf.cyl[7:0] <= w_data[7:0];
    end
    if (!RST_I && wr_go && w_strb[1] && aw_addr == ADDR_CYL) tf.cyl[15:8] <= w_data[15:8];
  end

  // Vendor attribute table: loaded by firmware, read back at ADDR_ATTR_DATA
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sel_attr <= 8'h00;
    end else if (wr_go && w_strb[0] && aw_addr == ADDR_ATTR_SEL) begin
      sel_attr <= w_data[7:0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_ATTR; i++) attr[i] <= ATTR_RESET;
    end else if (wr_go && aw_addr == ADDR_ATTR_LOAD && sel_attr < 8'(NUM_ATTR)) begin
      attr[sel_attr[2:0]] <= w_data; // [RULE17]
    end
  end

  // Attribute slot to ID: flash id, two erase counts, two block counts, firmware
  function automatic logic [7:0] attr_id(input logic [2:0] s);
    case (s)
      3'h0: return ATTR_FLASH_ID; // [RULE16]
      3'h1, 3'h2: return ATTR_ERASE;
      3'h3, 3'h4: return ATTR_BLOCKS;
      default: return ATTR_FW;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode and issue; head masked for select-only commands
  atacd_dec_t dec;
  logic [7:0] opcode;
  logic [7:0] status;

  atacd_decode u_dec (
    .opcode_i(w_data[7:0]),
    .dec_o(dec)
  );

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      CMD_STROBE_O <= 1'b0;
      CMD_KIND_O <= ATACD_NONE;
      CMD_OPCODE_O <= 8'h00;
      CMD_ARGS_O <= '0;
      CMD_LBA_O <= 28'h000_0000;
      CMD_LBA_MODE_O <= 1'b0;
      CMD_USE_O <= 7'h00;
      status <= 8'h00;
      opcode <= 8'h00;
    end else begin
      CMD_STROBE_O <= cmd_wr && !dec.abort; // [RULE18]
      if (cmd_wr) begin
        opcode <= w_data[7:0];
        CMD_KIND_O <= dec.cmd;
        CMD_OPCODE_O <= w_data[7:0];
        CMD_USE_O <= dec.use_mask;
        // Unused fields zeroed so downstream never sees stale arguments
        CMD_ARGS_O.feature <= dec.use_mask[U_FEAT] ? tf.feature : 8'h00; // [RULE12] [RULE9]
        CMD_ARGS_O.count <= dec.use_mask[U_COUNT] ? tf.count : 8'h00; // [RULE10] [RULE7]
        CMD_ARGS_O.secnum <= dec.use_mask[U_SECNUM] ? tf.secnum : 8'h00;
        CMD_ARGS_O.cyl <= dec.use_mask[U_CYL] ? tf.cyl : 16'h0000;
        CMD_ARGS_O.devhead <= {3'b000, dec.use_mask[U_DRV] & tf.devhead[DH_DRV_BIT],
                               dec.use_mask[U_HEAD] ? tf.devhead[3:0] : 4'h0}; // [RULE13] [RULE14]
        CMD_LBA_MODE_O <= dec.use_mask[U_LBA] && tf.devhead[DH_LBA_BIT]; // [RULE15]
        CMD_LBA_O <= (dec.use_mask[U_LBA] && tf.devhead[DH_LBA_BIT]) ?
                     {tf.devhead[3:0], tf.cyl, tf.secnum} : 28'h000_0000; // [RULE15]
        status <= {4'h0, dec.use_mask[U_LBA] && tf.devhead[DH_LBA_BIT],
                   dec.xfer && !dec.abort, dec.abort, 1'b1}; // [RULE18]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    unique case (S_AXI_ARADDR_I[7:0])
      ADDR_FEATURE: rd_val = {24'h0, tf.feature};
      ADDR_COUNT: rd_val = {24'h0, tf.count};
      ADDR_SECNUM: rd_val = {24'h0, tf.secnum};
      ADDR_CYL: rd_val = {16'h0, tf.cyl};
      ADDR_DEVHEAD: rd_val = {24'h0, tf.devhead};
      ADDR_COMMAND: rd_val = {24'h0, opcode};
      ADDR_STATUS: rd_val = {24'h0, status};
      ADDR_USAGE: rd_val = {25'h0, CMD_USE_O};
      ADDR_LBA: rd_val = {4'h0, CMD_LBA_O};
      ADDR_ATTR_SEL: rd_val = {24'h0, sel_attr};
      ADDR_ATTR_DATA: rd_val = (sel_attr < 8'(NUM_ATTR)) ?
                               attr[sel_attr[2:0]] : 32'h0000_0000;
      ADDR_ATTR_LOAD: rd_val = (sel_attr < 8'(NUM_ATTR)) ?
                               {24'h0, attr_id(sel_attr[2:0])} : 32'h0000_0000; // [RULE16]
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= 2'b00;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_val;
      S_AXI_RRESP_O <= rd_ok ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_abort_no_strobe;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      cmd_wr && dec.abort |=> !CMD_STROBE_O && status[ST_ABORT] && !status[ST_XFER];
  endproperty
  a_abort_no_strobe: assert property (p_abort_no_strobe) else $error("abort missed"); // [RULE18]
  property p_abort_use;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      cmd_wr && dec.abort |=> CMD_USE_O == 7'h00 && CMD_KIND_O == ATACD_BAD;
  endproperty
  a_abort_use: assert property (p_abort_use) else $error("bad opcode kept fields"); // [RULE18]
  property p_seek;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      cmd_wr && w_data[7:4] == 4'h7 |=> CMD_STROBE_O && CMD_KIND_O == ATACD_SEEK;
  endproperty
  a_seek: assert property (p_seek) else $error("7x not seek"); // [RULE8]
  property p_head_masked;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      CMD_STROBE_O && !CMD_USE_O[U_HEAD] |-> CMD_ARGS_O.devhead[3:0] == 4'h0;
  endproperty
  a_head_masked: assert property (p_head_masked) else $error("head leaked"); // [RULE14]
  property p_head_kept;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      cmd_wr && dec.use_mask[U_HEAD] |=> CMD_ARGS_O.devhead[3:0] == $past(tf.devhead[3:0]);
  endproperty
  a_head_kept: assert property (p_head_kept) else $error("head lost"); // [RULE13]
  property p_unused_zero;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      CMD_STROBE_O && !CMD_USE_O[U_FEAT] |-> CMD_ARGS_O.feature == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused field"); // [RULE12]
  property p_lba;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      CMD_STROBE_O && CMD_LBA_MODE_O |-> CMD_LBA_O[7:0] == CMD_ARGS_O.secnum;
  endproperty
  a_lba: assert property (p_lba) else $error("lba mismatch"); // [RULE15]
  property p_read_kind;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      cmd_wr && w_data[7:0] == 8'hc9 |=> CMD_KIND_O == ATACD_RDMA && CMD_USE_O == 7'h7e;
  endproperty
  a_read_kind: assert property (p_read_kind) else $error("c9 decode"); // [RULE3]
  property p_setf;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      cmd_wr && w_data[7:0] == 8'hef |=> CMD_ARGS_O.feature == $past(tf.feature);
  endproperty
  a_setf: assert property (p_setf) else $error("feature lost"); // [RULE9]
  c_abort: cover property (@(posedge CLK_SYS_I) cmd_wr && dec.abort);
  c_lba: cover property (@(posedge CLK_SYS_I) CMD_STROBE_O && CMD_LBA_MODE_O);
  c_smart: cover property (@(posedge CLK_SYS_I) CMD_STROBE_O && CMD_KIND_O == ATACD_SMART);
endmodule

// ===== verif/atacd_host_model.sv
`timescale 1ns/100ps
module atacd_host_model (
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    awaddr_o = 8'h00;
    araddr_o = 8'h00;
    wdata_o = 32'h0;
    wstrb_o = 4'hf;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Handshakes judged at the falling edge, acted on at the next rising edge,
  // so no race with the slave's own updates. Released payload shows the inverse.
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk_i);
      aw = awvalid_o & awready_i;
      w = wvalid_o & wready_i;
      b = bvalid_i & bready_o;
      r = bresp_i;
      @(posedge clk_i);
      if (aw) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (w) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (b) bready_o <= 1'b0;
    end
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clk_i);
      ar = arvalid_o & arready_i;
      rv = rvalid_i & rready_o;
      d = rdata_i;
      r = rresp_i;
      @(posedge clk_i);
      if (ar) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rv) rready_o <= 1'b0;
    end
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
  import atacd_pkg::*;
  // {opcode, kind, usage mask}; kind 18 marks an unsupported opcode
  localparam logic [23:0] CMDS [37] = '{
    24'he50110, 24'he30212, 24'he10310, 24'he20410, 24'he00510, 24'he60610, 24'hc8077e,
    24'hc9077e, 24'hc4087e, 24'h20097e, 24'h21097e, 24'h400a7e, 24'h410a7e, 24'hca0b7e,
    24'hc50c7e, 24'h300d7e, 24'hf10e10, 24'hf20e10, 24'hf30e10, 24'hf40e10, 24'hf50e10,
    24'hf60e10, 24'h900f10, 24'he71010, 24'hec1110, 24'h101210, 24'h911332, 24'h701438,
    24'h7a1438, 24'h7f1438, 24'hef1511, 24'hc61612, 24'hb0171f, 24'h001800, 24'hff1800,
    24'h121800, 24'hb11800};
  localparam logic [7:0] IDS [6] = '{8'he5, 8'hea, 8'hea, 8'heb, 8'heb, 8'he8};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr, opcode, fe, cn, sn, dh;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, strobe, lba_mode;
  logic [15:0] cy;
  logic [27:0] lba;
  logic [6:0] use_mask;
  atacd_cmd_t kind;
  atacd_tf_t args;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_strobe = 0;

  atacd_host_model host (.clk_i(clk_sys), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
  atacd_top uut (.CLK_SYS_I(clk_sys), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .CMD_STROBE_O(strobe), .CMD_KIND_O(kind),
    .CMD_OPCODE_O(opcode), .CMD_ARGS_O(args), .CMD_LBA_O(lba), .CMD_LBA_MODE_O(lba_mode),
    .CMD_USE_O(use_mask));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // Pulse is one cycle wide; counted where it is settled
  always @(negedge clk_sys) begin
    if (strobe === 1'b1) n_strobe++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.write(a, d, rr);
    chk("bresp", 2'b00, rr);
  endtask
  task automatic issue(input logic [23:0] e);
    logic [7:0] op, dx;
    logic [6:0] m;
    logic bad;
    logic xf;
    int s0;
    op = e[23:16];
    m = e[6:0];
    bad = (e[12:8] == 5'h18);
    xf = e[12:8] inside {5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h11, 5'h17};
    dx = {3'h0, m[U_DRV] & dh[DH_DRV_BIT], m[U_HEAD] ? dh[3:0] : 4'h0};
    wr(ADDR_FEATURE, {24'h0, fe});
    wr(ADDR_COUNT, {24'h0, cn});
    wr(ADDR_SECNUM, {24'h0, sn});
    wr(ADDR_CYL, {16'h0, cy});
    wr(ADDR_DEVHEAD, {24'h0, dh});
    s0 = n_strobe;
    wr(ADDR_COMMAND, {24'h0, op});
    chk("kind", e[12:8], kind);
    chk("opcode", op, opcode);
    chk("strobe", !bad, n_strobe - s0);
    host.read(ADDR_STATUS, rv, rr);
    chk("abort", bad, rv[ST_ABORT]);
    chk("status", {m[U_LBA] & dh[DH_LBA_BIT], xf, bad, 1'b1}, rv[3:0]);
    host.read(ADDR_COMMAND, rv, rr);
    chk("readback", op, rv);
    if (!bad) begin
      chk("use", m, use_mask);
      chk("args", {m[U_FEAT] ? fe : 8'h0, m[U_COUNT] ? cn : 8'h0, m[U_SECNUM] ? sn : 8'h0,
        m[U_CYL] ? cy : 16'h0, dx}, args);
      chk("lba_mode", m[U_LBA] & dh[DH_LBA_BIT], lba_mode);
      chk("lba", (m[U_LBA] & dh[DH_LBA_BIT]) ? {dh[3:0], cy, sn} : 28'h0, lba);
    end
  endtask
  // Both passes run every CMDS entry; the second clears the address mode and drive bits
  task automatic sweep(input logic [47:0] f);
    {fe, cn, sn, cy, dh} = f;
    for (int i = 0; i < 37; i++) begin
      issue(CMDS[i]);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    sweep(48'ha53c5a_1234_5f);
    sweep(48'h81c396_edcb_2b);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_ATTR_SEL, i);
      host.read(ADDR_ATTR_LOAD, rv, rr);
      chk("attr_id", IDS[i], rv);
      host.read(ADDR_ATTR_DATA, rv, rr);
      chk("attr_reset", ATTR_RESET, rv);
      wr(ADDR_ATTR_LOAD, 32'h5a00_0000 + i);
      host.read(ADDR_ATTR_DATA, rv, rr);
      chk("attr_value", 32'h5a00_0000 + i, rv);
    end
    host.write(8'h3c, 32'hffff_ffff, rr);
    chk("bresp_unmapped", 2'b10, rr);
    host.read(8'h3c, rv, rr);
    chk("rresp_unmapped", 2'b10, rr);
    chk("rdata_unmapped", 32'h0, rv);
    print_verdict();
  end
endmodule
